// ===== dchp_pkg.sv
// Constants shared by the dual channel host port
package dchp_pkg;
    // Internal CPU addresses
    localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL = 16'hffc3;
    localparam logic [15:0] ADDR_SYSTEM_CONTROL = 16'hffc4;
    localparam logic [15:0] ADDR_HOST_PORT_CONTROL = 16'hfff0;
    localparam logic [15:0] ADDR_CHAN1_INPUT_BYTE = 16'hfff4;
    localparam logic [15:0] ADDR_CHAN1_OUTPUT_BYTE = 16'hfff5;
    localparam logic [15:0] ADDR_CHAN1_FLAGS = 16'hfff6;
    localparam logic [15:0] ADDR_CHAN2_INPUT_BYTE = 16'hfffc;
    localparam logic [15:0] ADDR_CHAN2_OUTPUT_BYTE = 16'hfffd;
    localparam logic [15:0] ADDR_CHAN2_FLAGS = 16'hfffe;
    // Upper twelve address bits of the gated range
    localparam logic [11:0] PORT_RANGE_HI = 12'hfff;
    // Reset values
    localparam logic [7:0] SERIAL_TIMER_RESET = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h09;
    localparam logic [7:0] HOST_PORT_CONTROL_RESET = 8'hf8;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // System control fields
    localparam int SYS_PORT_ENABLE = 1;
    localparam logic [7:0] SYS_RO_MASK = 8'h08;
    // Host port control fields
    localparam int HPC_FAST_GATE_EN = 0;
    localparam int HPC_IRQ_EN1 = 1;
    localparam int HPC_IRQ_EN2 = 2;
    localparam logic [7:0] HPC_ONES_MASK = 8'hf8;
    // Channel flag fields
    localparam int FLG_OUTPUT_FULL = 0;
    localparam int FLG_INPUT_FULL = 1;
    localparam int FLG_USER_LOW = 2;
    localparam int FLG_CMD_DATA = 3;
    localparam logic [7:0] FLG_USER_MASK = 8'hf4;
    // Fast gate command byte and gate data bit
    localparam logic [7:0] GATE_CMD_DEF = 8'hd1;
    localparam int GATE_DATA_BIT = 1;
    localparam logic GATE_RESET = 1'b1;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : dchp_pkg

// ===== dchp_chan_if.sv
// Signals between the port top and one mailbox channel
`timescale 1ns/100ps
interface dchp_chan_if;
    logic host_wr;
    logic host_rd_out;
    logic [7:0] host_data;
    logic host_cmd;
    logic cpu_rd_in;
    logic cpu_wr_out;
    logic cpu_wr_flags;
    logic [7:0] cpu_wdata;
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    logic [7:0] flags;
    modport chan (
        input host_wr,
        input host_rd_out,
        input host_data,
        input host_cmd,
        input cpu_rd_in,
        input cpu_wr_out,
        input cpu_wr_flags,
        input cpu_wdata,
        output in_byte,
        output out_byte,
        output flags
    );
    modport ctl (
        output host_wr,
        output host_rd_out,
        output host_data,
        output host_cmd,
        output cpu_rd_in,
        output cpu_wr_out,
        output cpu_wr_flags,
        output cpu_wdata,
        input in_byte,
        input out_byte,
        input flags
    );
endinterface : dchp_chan_if

// ===== dchp_chan.sv
// One mailbox channel: input byte, output byte and flag register
`timescale 1ns/100ps
module dchp_chan (
    input wire logic clk,
    input wire logic arst_n,
    dchp_chan_if.chan cif
);
    logic [7:0] idr_q;
    logic [7:0] idr_d;
    logic [7:0] odr_q;
    logic [7:0] odr_d;
    logic [7:0] flg_q;
    logic [7:0] flg_d;

    always_comb
    begin
        idr_d = idr_q;
        odr_d = odr_q;
        flg_d = flg_q;
        if (cif.cpu_wr_flags)
        begin
            // Hardware bits keep their value
            flg_d = (flg_q & ~dchp_pkg::FLG_USER_MASK)
                | (cif.cpu_wdata & dchp_pkg::FLG_USER_MASK);
        end
        if (cif.host_rd_out)
        begin
            flg_d[dchp_pkg::FLG_OUTPUT_FULL] = 1'b0;
        end
        if (cif.cpu_wr_out)
        begin
            odr_d = cif.cpu_wdata;
            // Set after clear so a coincident set wins
            flg_d[dchp_pkg::FLG_OUTPUT_FULL] = 1'b1;
        end
        if (cif.cpu_rd_in)
        begin
            flg_d[dchp_pkg::FLG_INPUT_FULL] = 1'b0;
        end
        if (cif.host_wr)
        begin
            idr_d = cif.host_data;
            flg_d[dchp_pkg::FLG_CMD_DATA] = cif.host_cmd;
            flg_d[dchp_pkg::FLG_INPUT_FULL] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idr_q <= dchp_pkg::BYTE_RESET;
            odr_q <= dchp_pkg::BYTE_RESET;
            flg_q <= dchp_pkg::FLAGS_RESET;
        end
        else
        begin
            idr_q <= idr_d;
            odr_q <= odr_d;
            flg_q <= flg_d;
        end
    end

    assign cif.in_byte = idr_q;
    assign cif.out_byte = odr_q;
    assign cif.flags = flg_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_host_write;
        cif.host_wr;
    endsequence

    chk_ibf_set: assert property (s_host_write |=> flg_q[1])
        else $error("input full not set by host write");
    chk_ibf_clear: assert property
        (cif.cpu_rd_in && !cif.host_wr |=> !flg_q[1])
        else $error("input full not cleared by cpu read");
    chk_obf_set: assert property (cif.cpu_wr_out |=> flg_q[0])
        else $error("output full not set by cpu write");
    chk_obf_clear: assert property
        (cif.host_rd_out && !cif.cpu_wr_out |=> !flg_q[0])
        else $error("output full not cleared by host read");
    chk_capture_cd: assert property (s_host_write |=>
        idr_q == $past(cif.host_data) && flg_q[3] == $past(cif.host_cmd))
        else $error("host byte or command mark not captured");
    chk_user_bits: assert property
        (cif.cpu_wr_flags && !cif.host_wr |=>
        flg_q[7:4] == $past(cif.cpu_wdata[7:4])
        && flg_q[2] == $past(cif.cpu_wdata[2])
        && flg_q[3] == $past(flg_q[3]))
        else $error("user flag bits not written as expected");
endmodule : dchp_chan

// ===== dchp_top.sv
// Dual channel parallel host port with internal CPU register access
// What this block does
// - The whole port works only while the port enable bit is set.
// - Storage is four data bytes, two flag bytes and three control bytes.
// - A low on only one of select one or select two picks channel one or two.
// - On a host read the command line picks flags or output byte.
// - On a host write the command line marks the byte command or data.
// - Channel one: host writes input, reads output and flags only.
// - Channel two has the same access pattern at its own addresses.
// - CPU access to the upper port range works only when enabled.
// - User flag bits are CPU writable, the others read only.
// - The byte bus is driven only in host reads, sampled in writes.
// - Three host interrupt outputs and one address gate output.
// - Write strobe rise captures the bus and the command mark.
// - Output byte drives the bus on low command, select and read.
// - Input full sets on host write, clears on CPU input read.
// - Output full sets on CPU output write, clears on host output byte read.
`timescale 1ns/100ps
module dchp_top #(
    parameter logic [7:0] GATE_CMD = dchp_pkg::GATE_CMD_DEF
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [15:0] CPU_ADDR,
    input wire logic [7:0] CPU_WDATA,
    input wire logic CPU_RE,
    input wire logic CPU_WE,
    output logic [7:0] CPU_RDATA,
    output logic IN_FULL_IRQ1,
    output logic IN_FULL_IRQ2,
    input wire logic CHAN1_SELECT_N,
    input wire logic CHAN2_SELECT_N,
    input wire logic CMD_ADDR_LINE,
    input wire logic HOST_READ_STROBE_N,
    input wire logic HOST_WRITE_STROBE_N,
    input wire logic [7:0] HOST_BUS_I,
    output logic [7:0] HOST_BUS_O,
    output logic HOST_BUS_OE,
    output logic HOST_IRQ_ONE,
    output logic HOST_IRQ_ELEVEN,
    output logic HOST_IRQ_TWELVE,
    output logic ADDR_GATE_OUT
);
    dchp_chan_if c1 ();
    dchp_chan_if c2 ();

    // Host pin samples of the previous cycle and the registered host bus byte
    logic rdn_q;
    logic rdn_d;
    logic wrn_q;
    logic wrn_d;
    logic cs1n_q;
    logic cs1n_d;
    logic cs2n_q;
    logic cs2n_d;
    logic cmd_q;
    logic cmd_d;
    logic [7:0] hd_q;
    logic [7:0] hd_d;
    logic [7:0] bus_q;
    logic [7:0] bus_d;

    // CPU side registers
    logic [7:0] sys_q;
    logic [7:0] sys_d;
    logic [7:0] stc_q;
    logic [7:0] stc_d;
    logic [7:0] hpc_q;
    logic [7:0] hpc_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic gate_q;
    logic gate_d;
    logic arm_q;
    logic arm_d;

    logic port_enable_bit;
    logic sel1;
    logic sel2;
    logic sel1_q;
    logic sel2_q;
    logic wr_rise;
    logic rd_rise;
    logic in_rng;
    logic acc_ok;
    logic we;
    logic re;
    logic [7:0] rd_val;

    assign port_enable_bit = sys_q[dchp_pkg::SYS_PORT_ENABLE];

    // Both selects low is treated as no channel
    assign sel1 = !CHAN1_SELECT_N && CHAN2_SELECT_N;
    assign sel2 = CHAN1_SELECT_N && !CHAN2_SELECT_N;
    assign sel1_q = !cs1n_q && cs2n_q;
    assign sel2_q = cs1n_q && !cs2n_q;
    assign wr_rise = !wrn_q && HOST_WRITE_STROBE_N;
    assign rd_rise = !rdn_q && HOST_READ_STROBE_N;

    // Host write and read events, decoded from the cycle before the edge
    assign c1.host_wr = port_enable_bit && wr_rise && sel1_q;
    assign c2.host_wr = port_enable_bit && wr_rise && sel2_q;
    assign c1.host_rd_out = port_enable_bit && rd_rise && sel1_q && !cmd_q;
    assign c2.host_rd_out = port_enable_bit && rd_rise && sel2_q && !cmd_q;
    assign c1.host_data = hd_q;
    assign c2.host_data = hd_q;
    assign c1.host_cmd = cmd_q;
    assign c2.host_cmd = cmd_q;

    // CPU access gating of the upper port range
    assign in_rng = CPU_ADDR[15:4] == dchp_pkg::PORT_RANGE_HI;
    assign acc_ok = !in_rng || port_enable_bit;
    assign we = CPU_WE && acc_ok;
    assign re = CPU_RE && acc_ok;

    assign c1.cpu_rd_in = re && CPU_ADDR == dchp_pkg::ADDR_CHAN1_INPUT_BYTE;
    assign c2.cpu_rd_in = re && CPU_ADDR == dchp_pkg::ADDR_CHAN2_INPUT_BYTE;
    assign c1.cpu_wr_out = we && CPU_ADDR == dchp_pkg::ADDR_CHAN1_OUTPUT_BYTE;
    assign c2.cpu_wr_out = we && CPU_ADDR == dchp_pkg::ADDR_CHAN2_OUTPUT_BYTE;
    assign c1.cpu_wr_flags = we && CPU_ADDR == dchp_pkg::ADDR_CHAN1_FLAGS;
    assign c2.cpu_wr_flags = we && CPU_ADDR == dchp_pkg::ADDR_CHAN2_FLAGS;
    assign c1.cpu_wdata = CPU_WDATA;
    assign c2.cpu_wdata = CPU_WDATA;

    // Two identical channels
    dchp_chan u_chan1 (
        .clk(CLK),
        .arst_n(ARST_N),
        .cif(c1)
    );

    dchp_chan u_chan2 (
        .clk(CLK),
        .arst_n(ARST_N),
        .cif(c2)
    );

    // Host pin sampling and read data register
    always_comb
    begin
        rdn_d = HOST_READ_STROBE_N;
        wrn_d = HOST_WRITE_STROBE_N;
        cs1n_d = CHAN1_SELECT_N;
        cs2n_d = CHAN2_SELECT_N;
        cmd_d = CMD_ADDR_LINE;
        hd_d = HOST_BUS_I;
        bus_d = bus_q;
        // Input bytes are never offered to the host
        if (sel1)
        begin
            bus_d = CMD_ADDR_LINE ? c1.flags : c1.out_byte;
        end
        else if (sel2)
        begin
            bus_d = CMD_ADDR_LINE ? c2.flags : c2.out_byte;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdn_q <= 1'b1;
            wrn_q <= 1'b1;
            cs1n_q <= 1'b1;
            cs2n_q <= 1'b1;
            cmd_q <= 1'b0;
            hd_q <= dchp_pkg::BYTE_RESET;
            bus_q <= dchp_pkg::BYTE_RESET;
        end
        else
        begin
            rdn_q <= rdn_d;
            wrn_q <= wrn_d;
            cs1n_q <= cs1n_d;
            cs2n_q <= cs2n_d;
            cmd_q <= cmd_d;
            hd_q <= hd_d;
            bus_q <= bus_d;
        end
    end

    // Driven only while a channel is read
    assign HOST_BUS_OE = port_enable_bit && !HOST_READ_STROBE_N && (sel1 || sel2);
    assign HOST_BUS_O = bus_q;

    // CPU read mux
    always_comb
    begin
        rd_val = dchp_pkg::UNMAPPED_READ;
        if (acc_ok)
        begin
            case (CPU_ADDR)
                dchp_pkg::ADDR_SERIAL_TIMER_CONTROL: rd_val = stc_q;
                dchp_pkg::ADDR_SYSTEM_CONTROL: rd_val = sys_q;
                dchp_pkg::ADDR_HOST_PORT_CONTROL: rd_val = hpc_q;
                dchp_pkg::ADDR_CHAN1_INPUT_BYTE: rd_val = c1.in_byte;
                dchp_pkg::ADDR_CHAN1_OUTPUT_BYTE: rd_val = c1.out_byte;
                dchp_pkg::ADDR_CHAN1_FLAGS: rd_val = c1.flags;
                dchp_pkg::ADDR_CHAN2_INPUT_BYTE: rd_val = c2.in_byte;
                dchp_pkg::ADDR_CHAN2_OUTPUT_BYTE: rd_val = c2.out_byte;
                dchp_pkg::ADDR_CHAN2_FLAGS: rd_val = c2.flags;
                default: rd_val = dchp_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // Control registers and fast gate
    always_comb
    begin
        sys_d = sys_q;
        stc_d = stc_q;
        hpc_d = hpc_q;
        rdata_d = rdata_q;
        gate_d = gate_q;
        arm_d = arm_q;
        if (CPU_RE)
        begin
            rdata_d = rd_val;
        end
        if (we && CPU_ADDR == dchp_pkg::ADDR_SYSTEM_CONTROL)
        begin
            sys_d = (CPU_WDATA & ~dchp_pkg::SYS_RO_MASK)
                | (sys_q & dchp_pkg::SYS_RO_MASK);
        end
        if (we && CPU_ADDR == dchp_pkg::ADDR_SERIAL_TIMER_CONTROL)
        begin
            stc_d = CPU_WDATA;
        end
        if (we && CPU_ADDR == dchp_pkg::ADDR_HOST_PORT_CONTROL)
        begin
            // Reserved bits always held at one, read back as one while the port is enabled
            hpc_d = CPU_WDATA | dchp_pkg::HPC_ONES_MASK;
        end
        // Gate command, then a data byte whose bit sets the gate level
        if (c1.host_wr && hpc_q[dchp_pkg::HPC_FAST_GATE_EN])
        begin
            if (cmd_q)
            begin
                arm_d = hd_q == GATE_CMD;
            end
            else if (arm_q)
            begin
                gate_d = hd_q[dchp_pkg::GATE_DATA_BIT];
                arm_d = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sys_q <= dchp_pkg::SYSTEM_CONTROL_RESET;
            stc_q <= dchp_pkg::SERIAL_TIMER_RESET;
            hpc_q <= dchp_pkg::HOST_PORT_CONTROL_RESET;
            rdata_q <= dchp_pkg::UNMAPPED_READ;
            gate_q <= dchp_pkg::GATE_RESET;
            arm_q <= 1'b0;
        end
        else
        begin
            sys_q <= sys_d;
            stc_q <= stc_d;
            hpc_q <= hpc_d;
            rdata_q <= rdata_d;
            gate_q <= gate_d;
            arm_q <= arm_d;
        end
    end

    assign CPU_RDATA = rdata_q;
    assign IN_FULL_IRQ1 = port_enable_bit && hpc_q[dchp_pkg::HPC_IRQ_EN1]
        && c1.flags[dchp_pkg::FLG_INPUT_FULL];
    assign IN_FULL_IRQ2 = port_enable_bit && hpc_q[dchp_pkg::HPC_IRQ_EN2]
        && c2.flags[dchp_pkg::FLG_INPUT_FULL];

    // User bit 2 of channel one steers its output full to the second line
    assign HOST_IRQ_ONE = port_enable_bit && c1.flags[dchp_pkg::FLG_OUTPUT_FULL]
        && !c1.flags[dchp_pkg::FLG_USER_LOW];
    assign HOST_IRQ_TWELVE = port_enable_bit && c1.flags[dchp_pkg::FLG_OUTPUT_FULL]
        && c1.flags[dchp_pkg::FLG_USER_LOW];
    assign HOST_IRQ_ELEVEN = port_enable_bit
        && c2.flags[dchp_pkg::FLG_OUTPUT_FULL];
    assign ADDR_GATE_OUT = gate_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_rd1_out;
        port_enable_bit && !CHAN1_SELECT_N && CHAN2_SELECT_N && !CMD_ADDR_LINE
            && !HOST_READ_STROBE_N;
    endsequence

    sequence s_rd2_flags;
        port_enable_bit && CHAN1_SELECT_N && !CHAN2_SELECT_N && CMD_ADDR_LINE
            && !HOST_READ_STROBE_N;
    endsequence

    chk_port_idle: assert property (!port_enable_bit |-> !HOST_BUS_OE
        && !c1.host_wr && !c2.host_wr && !HOST_IRQ_ONE)
        else $error("port active while disabled");
    chk_out_drive: assert property (s_rd1_out ##1 s_rd1_out |->
        HOST_BUS_OE && HOST_BUS_O == $past(c1.out_byte))
        else $error("channel one output byte not on bus");
    chk_flag_drive: assert property (s_rd2_flags ##1 s_rd2_flags |->
        HOST_BUS_OE && HOST_BUS_O == $past(c2.flags))
        else $error("channel two flags not on bus");
    chk_cpu_gate: assert property (!port_enable_bit && CPU_WE && in_rng |=>
        $stable(c1.out_byte) && $stable(c2.out_byte) && $stable(hpc_q))
        else $error("port range written while disabled");
    chk_host_cap: assert property (port_enable_bit && !HOST_WRITE_STROBE_N && sel2
        ##1 HOST_WRITE_STROBE_N |=> c2.in_byte == $past(hd_q))
        else $error("channel two write not captured");
endmodule : dchp_top

// ===== dchp_host.sv
// Host processor model driving the port pins
`timescale 1ns/100ps
module dchp_host (
    input wire logic clk,
    input wire logic [7:0] bus_o,
    input wire logic bus_oe,
    output logic sel1_n,
    output logic sel2_n,
    output logic cmd,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] bus_i
);
    logic drv = 1'b0;
    logic [7:0] dat = 8'h00;
    logic [7:0] last = 8'h00;
    initial
    begin
        {sel2_n, sel1_n} = 2'b11;
        cmd = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end
    // Released bus shows the inverse, not a stale copy
    always_comb bus_i = bus_oe ? bus_o : (drv ? dat : ~last);
    always @(posedge clk)
    begin
        if (drv)
            last <= dat;
    end
    task hw(input logic [1:0] s, input logic c, input logic [7:0] d);
        @(posedge clk);
        {sel2_n, sel1_n} <= s;
        cmd <= c;
        dat <= d;
        drv <= 1'b1;
        wr_n <= 1'b0;
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        {sel2_n, sel1_n} <= 2'b11;
        drv <= 1'b0;
    endtask : hw
    task hr(input logic [1:0] s, input logic c, output logic [7:0] d,
            output logic oe);
        @(posedge clk);
        {sel2_n, sel1_n} <= s;
        cmd <= c;
        rd_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        d = bus_i;
        oe = bus_oe;
        @(posedge clk);
        rd_n <= 1'b1;
        {sel2_n, sel1_n} <= 2'b11;
    endtask : hr
endmodule : dchp_host

// ===== tb_top.sv
// Self-checking bench for the dual channel host port
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic re = 1'b0;
    logic we = 1'b0;
    logic [7:0] rdata, bo, bi, rnd, v, d, o, u;
    logic irq1, irq2, hone, helev, htwel, gate, s1n, s2n, cmd, rdn, wrn;
    logic oe, c, e;
    logic [1:0] sn;
    logic [15:0] ba;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    dchp_top dut (.CLK(clk), .ARST_N(arst_n), .CPU_ADDR(addr),
        .CPU_WDATA(wdata), .CPU_RE(re), .CPU_WE(we), .CPU_RDATA(rdata),
        .IN_FULL_IRQ1(irq1), .IN_FULL_IRQ2(irq2), .CHAN1_SELECT_N(s1n),
        .CHAN2_SELECT_N(s2n), .CMD_ADDR_LINE(cmd),
        .HOST_READ_STROBE_N(rdn), .HOST_WRITE_STROBE_N(wrn),
        .HOST_BUS_I(bi), .HOST_BUS_O(bo), .HOST_BUS_OE(oe),
        .HOST_IRQ_ONE(hone), .HOST_IRQ_ELEVEN(helev),
        .HOST_IRQ_TWELVE(htwel), .ADDR_GATE_OUT(gate));
    dchp_host host (.clk(clk), .bus_o(bo), .bus_oe(oe), .sel1_n(s1n),
        .sel2_n(s2n), .cmd(cmd), .rd_n(rdn), .wr_n(wrn), .bus_i(bi));
    initial
    begin
        forever #50 clk = ~clk;
    end
    function logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx
    // Expected flag byte from user bits and the three status bits
    function logic [7:0] flg(input logic [7:0] us, input logic cd,
                             input logic inf, input logic outf);
        return (us & dchp_pkg::FLG_USER_MASK) | {4'h0, cd, 1'b0, inf, outf};
    endfunction : flg
    task results;
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task cw(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : cw
    task cr(input logic [15:0] a, output logic [7:0] r);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        r = rdata;
    endtask : cr
    task crc(input logic [15:0] a, input logic [7:0] x);
        logic [7:0] r;
        cr(a, r);
        chk(r, x);
    endtask : crc
    // Hang guard; the full run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            results;
        end
    end
    initial
    begin
        rnd = 8'h06;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        crc(dchp_pkg::ADDR_SYSTEM_CONTROL, 8'h09);
        crc(dchp_pkg::ADDR_SERIAL_TIMER_CONTROL, 8'h00);
        chk({7'h0, gate}, 8'h01);
        cw(dchp_pkg::ADDR_HOST_PORT_CONTROL, 8'h07);
        crc(dchp_pkg::ADDR_HOST_PORT_CONTROL, 8'h00);
        host.hw(2'b10, 1'b0, 8'h5a);
        host.hr(2'b10, 1'b1, d, e);
        chk({7'h0, e}, 8'h00);
        cw(dchp_pkg::ADDR_SYSTEM_CONTROL, 8'h02);
        crc(dchp_pkg::ADDR_SYSTEM_CONTROL, 8'h0a);
        crc(dchp_pkg::ADDR_CHAN1_FLAGS, 8'h00);
        cw(dchp_pkg::ADDR_HOST_PORT_CONTROL, 8'h06);
        crc(dchp_pkg::ADDR_HOST_PORT_CONTROL, 8'hfe);
        crc(16'h1234, 8'h00);
        chk({7'h0, oe}, 8'h00);
        for (int ch = 1; ch <= 2; ch++)
        begin
            sn = (ch == 1) ? 2'b10 : 2'b01;
            ba = (ch == 1) ? dchp_pkg::ADDR_CHAN1_INPUT_BYTE :
                dchp_pkg::ADDR_CHAN2_INPUT_BYTE;
            for (int k = 0; k < 3; k++)
            begin
                rnd = nx(rnd);
                u = {rnd[7:3], k[0], rnd[1:0]};
                cw(ba + 16'h0002, u);
                rnd = nx(rnd);
                v = rnd;
                c = rnd[0];
                host.hw(sn, c, v);
                crc(ba + 16'h0002, flg(u, c, 1'b1, 1'b0));
                chk({7'h0, ((ch == 1) ? irq1 : irq2)}, 8'h01);
                crc(ba, v);
                crc(ba + 16'h0002, flg(u, c, 1'b0, 1'b0));
                rnd = nx(rnd);
                o = rnd;
                cw(ba + 16'h0001, o);
                crc(ba + 16'h0002, flg(u, c, 1'b0, 1'b1));
                e = (ch == 1) ? (u[2] ? htwel : hone) : helev;
                chk({7'h0, e}, 8'h01);
                host.hr(sn, 1'b1, d, e);
                chk(d, flg(u, c, 1'b0, 1'b1));
                chk({7'h0, e}, 8'h01);
                host.hr(sn, 1'b0, d, e);
                chk(d, o);
                repeat (2) @(posedge clk);
                crc(ba + 16'h0002, flg(u, c, 1'b0, 1'b0));
                chk({7'h0, (hone | htwel | helev)}, 8'h00);
            end
        end
        host.hw(2'b00, 1'b1, 8'h33);
        cr(dchp_pkg::ADDR_CHAN1_FLAGS, d);
        chk(d & 8'h02, 8'h00);
        cr(dchp_pkg::ADDR_CHAN2_FLAGS, d);
        chk(d & 8'h02, 8'h00);
        cw(dchp_pkg::ADDR_HOST_PORT_CONTROL, 8'h07);
        host.hw(2'b10, 1'b1, dchp_pkg::GATE_CMD_DEF);
        host.hw(2'b10, 1'b0, 8'h00);
        repeat (3) @(posedge clk);
        // Look between edges, never at the launching edge
        @(negedge clk);
        chk({7'h0, gate}, 8'h00);
        cw(dchp_pkg::ADDR_SYSTEM_CONTROL, 8'h00);
        crc(dchp_pkg::ADDR_CHAN1_OUTPUT_BYTE, 8'h00);
        host.hr(2'b10, 1'b0, d, e);
        chk({7'h0, e}, 8'h00);
        results;
    end
endmodule : tb_top
